// ==== src/stsel_pkg.sv ====
// stsel_pkg: constants, register map and types for the trial-run speed select block
// assumes a 100 MHz pclk and an APB slave with 32-bit data
package stsel_pkg;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL      = 8'h00; // servo-on, control mode, pending mode
  localparam logic [7:0] ADDR_JOG_SPEED = 8'h04; // jog speed in r/min
  localparam logic [7:0] ADDR_PRESET1   = 8'h08;
  localparam logic [7:0] ADDR_PRESET2   = 8'h0c;
  localparam logic [7:0] ADDR_PRESET3   = 8'h10;
  localparam logic [7:0] ADDR_DI_FUNC   = 8'h14; // one function code byte per input
  localparam logic [7:0] ADDR_STATUS    = 8'h18; // sticky events, write one to clear
  localparam logic [7:0] ADDR_MASK      = 8'h1c;
  localparam logic [7:0] ADDR_STATE     = 8'h20; // live state, read only
  localparam logic [7:0] ADDR_SPEED_CMD = 8'h24; // active speed command

  // ==========================================================================
  // control register fields
  localparam int CTRL_SW_SON_BIT  = 0;
  localparam int CTRL_MODE_LSB    = 4;
  localparam int CTRL_MODE_W      = 4;
  localparam int CTRL_ACTMODE_LSB = 8;

  // ==========================================================================
  // values
  localparam logic [3:0]  MODE_SPEED       = 4'h2;
  localparam logic [3:0]  MODE_RESET       = 4'h0;
  localparam logic [15:0] JOG_SPEED_RESET  = 16'h0014;  // 20 r/min
  localparam logic signed [31:0] PRESET_MAX = 32'sd50000;
  localparam logic signed [31:0] PRESET_MIN = -32'sd50000;
  localparam logic [7:0]  FUNC_NONE        = 8'h00;
  localparam logic [7:0]  FUNC_SERVO_ON    = 8'h01;
  localparam logic [7:0]  FUNC_ALARM_RST   = 8'h02;
  localparam logic [7:0]  FUNC_TRQ_LIMIT   = 8'h09;
  localparam logic [7:0]  FUNC_SPD_SEL0    = 8'h14;
  localparam logic [7:0]  FUNC_SPD_SEL1    = 8'h15;
  localparam logic [31:0] DI_FUNC_RESET    = 32'h1514_0901; // inputs 4..1

  // ==========================================================================
  // status bits
  localparam int ST_ALARM_CLR = 0;
  localparam int ST_JOG_ENTER = 1;
  localparam int ST_JOG_EXIT  = 2;
  localparam int ST_SRC_CHG   = 3;
  localparam int ST_W         = 4;

  // speed command sources
  typedef enum logic [1:0] {
    STSEL_SRC_ANALOG,
    STSEL_SRC_P1,
    STSEL_SRC_P2,
    STSEL_SRC_P3
  } stsel_src_t;

  // jog states
  typedef enum logic [1:0] {
    STSEL_JOG_IDLE,
    STSEL_JOG_ARMED,
    STSEL_JOG_RUN
  } stsel_jog_t;

endpackage : stsel_pkg

// ==== src/stsel_top.sv ====
// stsel_top: command selection for no-load trial runs of a servo drive
// assumes APB master on pclk; digital inputs and keys are asynchronous pins
`timescale 1ns/1ps
`default_nettype none

module stsel_top
  import stsel_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // digital input pins, one to four
  input  wire logic [3:0]  digital_in,
  // panel keys, level while held
  input  wire logic        key_set,
  input  wire logic        key_mode,
  input  wire logic        key_up,
  input  wire logic        key_down,
  input  wire logic        key_shift,
  // analog reference, already digitised, in 0.1 r/min
  input  wire logic signed [31:0] analog_speed,
  // alarm source
  input  wire logic        alarm_event,
  // drive outputs
  output logic             servo_enable,
  output logic             alarm_active,
  output logic             jog_active,
  output logic             torque_limit_active,
  output logic signed [31:0] speed_cmd,
  output logic             irq
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [1:0][3:0] di_sync;
    logic [1:0][4:0] key_sync;
    logic [4:0]      key_prev;
    logic            sw_son;
    logic [3:0]      mode_active;
    logic            mode_loaded;
    logic [15:0]     jog_speed;
    logic [2:0]      digit;
    logic signed [31:0] preset1;
    logic signed [31:0] preset2;
    logic signed [31:0] preset3;
    logic [31:0]     di_func;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    stsel_jog_t      jog;
    stsel_src_t      src;
    logic            alarm;
    logic            servo;
    logic            trq;
    logic signed [31:0] cmd;
    logic [31:0]     rdata;
  } stsel_state_t;

  stsel_state_t st;
  stsel_state_t next_st;

  // ==========================================================================
  // helpers
  // OR of the levels of every input assigned a function; code 0 never matches
  function automatic logic di_func_level(input logic [31:0] funcs,
                                         input logic [3:0]  lvl,
                                         input logic [7:0]  code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (funcs[i*8 +: 8] == code && code != FUNC_NONE) begin
        hit = hit | lvl[i];
      end
    end
    return hit;
  endfunction : di_func_level

  function automatic logic preset_ok(input logic [31:0] v);
    return ($signed(v) >= PRESET_MIN) && ($signed(v) <= PRESET_MAX);
  endfunction : preset_ok

  // one decimal digit weight for jog speed editing
  function automatic logic [15:0] digit_weight(input logic [2:0] d);
    logic [15:0] w;
    w = 16'h0001;
    for (int i = 0; i < 4; i++) begin
      if (i < int'(d)) begin
        w = 16'(w * 16'd10);
      end
    end
    return w;
  endfunction : digit_weight

  // ==========================================================================
  // combinational next state
  logic [3:0]  di;
  logic [4:0]  keys;
  logic [4:0]  key_rise;
  logic        apb_wr;
  logic        apb_rd;
  logic        sel0;
  logic        sel1;
  logic        son_in;
  logic        alarm_reset_input_in;
  logic        speed_mode;
  stsel_src_t  new_src;
  logic [15:0] w;

  assign pready  = 1'b1; // zero wait states
  assign pslverr = 1'b0;
  assign prdata  = st.rdata;
  assign servo_enable        = st.servo;
  assign alarm_active        = st.alarm;
  assign jog_active          = (st.jog == STSEL_JOG_RUN);
  assign torque_limit_active = st.trq;
  assign speed_cmd           = st.cmd;
  assign irq                 = |(st.status & st.mask);

  always_comb begin
    next_st  = st;
    di       = st.di_sync[1];
    keys     = st.key_sync[1];
    key_rise = keys & ~st.key_prev;
    apb_wr   = psel && penable && pwrite;
    apb_rd   = psel && !penable && !pwrite;
    w        = digit_weight(st.digit);

    // synchronisers: first stage read only by second
    next_st.di_sync[0]  = digital_in;
    next_st.di_sync[1]  = st.di_sync[0];
    next_st.key_sync[0] = {key_shift, key_down, key_up, key_mode, key_set};
    next_st.key_sync[1] = st.key_sync[0];
    next_st.key_prev    = keys;

    // mode is latched once after reset release
    if (!st.mode_loaded) begin
      next_st.mode_active = mode_store;
      next_st.mode_loaded = 1'b1;
    end
    speed_mode = (st.mode_active == MODE_SPEED);

    // input function decode
    son_in  = di_func_level(st.di_func, di, FUNC_SERVO_ON);
    alarm_reset_input_in = di_func_level(st.di_func, di, FUNC_ALARM_RST);
    sel0    = di_func_level(st.di_func, di, FUNC_SPD_SEL0);
    sel1    = di_func_level(st.di_func, di, FUNC_SPD_SEL1);
    next_st.trq = di_func_level(st.di_func, di, FUNC_TRQ_LIMIT);

    // servo enable: software force, or input level in speed mode only
    next_st.servo = st.sw_son || (speed_mode && son_in);

    // software clear goes first, so an event in the same cycle sets its bit again
    if (apb_wr && paddr == ADDR_STATUS) begin
      next_st.status = st.status & ~pwdata[ST_W-1:0];
    end

    // alarm: sticky until alarm reset input; event beats clear
    if (alarm_event) begin
      next_st.alarm = 1'b1;
    end else if (alarm_reset_input_in) begin
      next_st.alarm = 1'b0;
      if (st.alarm) begin
        next_st.status[ST_ALARM_CLR] = 1'b1;
      end
    end

    // jog state machine
    unique case (st.jog)
      STSEL_JOG_IDLE: begin
        if (key_rise[0]) begin
          next_st.jog = STSEL_JOG_ARMED;
        end
      end
      STSEL_JOG_ARMED: begin
        // digit editing of jog speed
        if (key_rise[2] && st.jog_speed <= 16'(16'hffff - w)) begin
          next_st.jog_speed = 16'(st.jog_speed + w);
        end else if (key_rise[3] && st.jog_speed >= w) begin
          next_st.jog_speed = 16'(st.jog_speed - w);
        end
        if (key_rise[4]) begin
          next_st.digit = (st.digit == 3'd3) ? 3'd0 : 3'(st.digit + 3'd1);
        end
        if (key_rise[0]) begin
          next_st.jog = STSEL_JOG_RUN;
          next_st.status[ST_JOG_ENTER] = 1'b1;
        end else if (key_rise[1]) begin
          next_st.jog = STSEL_JOG_IDLE;
        end
      end
      STSEL_JOG_RUN: begin
        if (key_rise[1]) begin
          next_st.jog = STSEL_JOG_IDLE;
          next_st.status[ST_JOG_EXIT] = 1'b1;
        end
      end
    endcase

    // speed source select from synchronised inputs
    new_src = stsel_src_t'({sel1, sel0});
    if (new_src != st.src) begin
      next_st.status[ST_SRC_CHG] = 1'b1;
    end
    next_st.src = new_src;

    // speed command: jog keys win while jogging
    if (st.jog == STSEL_JOG_RUN) begin
      if (keys[2]) begin
        next_st.cmd = $signed({16'h0000, st.jog_speed}) * 32'sd10;
      end else if (keys[3]) begin
        next_st.cmd = -($signed({16'h0000, st.jog_speed}) * 32'sd10);
      end else begin
        next_st.cmd = 32'sd0;
      end
    end else if (!next_st.servo) begin
      next_st.cmd = 32'sd0;
    end else begin
      unique case (st.src)
        STSEL_SRC_ANALOG: next_st.cmd = analog_speed;
        STSEL_SRC_P1:     next_st.cmd = st.preset1;
        STSEL_SRC_P2:     next_st.cmd = st.preset2;
        STSEL_SRC_P3:     next_st.cmd = st.preset3;
      endcase
    end

    // apb writes
    if (apb_wr) begin
      unique case (paddr)
        ADDR_CTRL: begin
          next_st.sw_son       = pwdata[CTRL_SW_SON_BIT];
        end
        ADDR_JOG_SPEED: next_st.jog_speed = pwdata[15:0];
        ADDR_PRESET1: if (preset_ok(pwdata)) next_st.preset1 = $signed(pwdata);
        ADDR_PRESET2: if (preset_ok(pwdata)) next_st.preset2 = $signed(pwdata);
        ADDR_PRESET3: if (preset_ok(pwdata)) next_st.preset3 = $signed(pwdata);
        ADDR_DI_FUNC: next_st.di_func = pwdata;
        ADDR_STATUS: ; // cleared above, ahead of the event logic, so set beats clear
        ADDR_MASK: next_st.mask = pwdata[ST_W-1:0];
        default: ;
      endcase
    end

    // apb read data captured in setup phase
    if (apb_rd) begin
      unique case (paddr)
        ADDR_CTRL: next_st.rdata = {20'h0, st.mode_active, mode_store, 3'h0, st.sw_son};
        ADDR_JOG_SPEED: next_st.rdata = {16'h0, st.jog_speed};
        ADDR_PRESET1:   next_st.rdata = st.preset1;
        ADDR_PRESET2:   next_st.rdata = st.preset2;
        ADDR_PRESET3:   next_st.rdata = st.preset3;
        ADDR_DI_FUNC:   next_st.rdata = st.di_func;
        ADDR_STATUS:    next_st.rdata = {28'h0, st.status};
        ADDR_MASK:      next_st.rdata = {28'h0, st.mask};
        ADDR_STATE:     next_st.rdata = {18'h0, st.digit, st.src, st.jog, st.trq,
                                         st.alarm, st.servo, di};
        ADDR_SPEED_CMD: next_st.rdata = st.cmd;
        default:        next_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // stored control mode setting; it must outlive a reset, because a new mode only
  // takes effect at the next reset release, so it has no reset and starts at the default
  logic [3:0] mode_store = MODE_RESET;

  always_ff @(posedge pclk) begin
    if (clk_en && apb_wr && paddr == ADDR_CTRL) begin
      mode_store <= pwdata[CTRL_MODE_LSB +: CTRL_MODE_W];
    end
  end

  // ==========================================================================
  // state register; clock enable freezes everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st              <= '0;
      st.mode_active  <= MODE_RESET;
      st.jog_speed    <= JOG_SPEED_RESET;
      st.di_func      <= DI_FUNC_RESET;
      st.jog          <= STSEL_JOG_IDLE;
      st.src          <= STSEL_SRC_ANALOG;
      st.alarm        <= 1'b0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

endmodule : stsel_top

`default_nettype wire

// ==== verification/stsel_top_asserts.sv ====
// checker for stsel_top: timing relations seen at the block's ports
// assumes one clock domain, pclk, with async active-low presetn
`timescale 1ns/1ps
`default_nettype none

module stsel_top_asserts
  import stsel_pkg::*;
(
  // clock, reset and apb
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               clk_en,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [7:0]         paddr,
  input wire logic [31:0]        pwdata,
  input wire logic               pready,
  input wire logic               pslverr,
  // keys, alarm source and drive outputs
  input wire logic               key_set,
  input wire logic               key_mode,
  input wire logic               key_up,
  input wire logic               key_down,
  input wire logic               alarm_event,
  input wire logic               servo_enable,
  input wire logic               alarm_active,
  input wire logic               jog_active,
  input wire logic signed [31:0] speed_cmd
);
  // ==========
  // all checks share pclk; reset masks them
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // a software servo-on write taken by the slave
  sequence s_son_write;
    psel && penable && pwrite && clk_en && paddr == ADDR_CTRL && pwdata[CTRL_SW_SON_BIT];
  endsequence
  // a jog key held long enough to pass the synchroniser
  sequence s_jog_up;
    (jog_active && key_up && !key_down)[*6];
  endsequence
  sequence s_jog_down;
    (jog_active && key_down && !key_up)[*6];
  endsequence

  chk_sw_servo_on: assert property (s_son_write |-> ##[1:3] servo_enable)
    else $error("servo not enabled after software servo-on write");
  chk_jog_enter_key: assert property ($rose(jog_active) |-> $past(key_set, 2) || $past(key_set, 3))
    else $error("jog entered without a set key press");
  chk_jog_mode_exit: assert property ($rose(key_mode) && jog_active |-> ##[2:6] !jog_active)
    else $error("jog not left after mode key");
  chk_jog_fwd_dir: assert property (s_jog_up |-> speed_cmd > 0)
    else $error("up key in jog did not give forward speed");
  chk_jog_rev_dir: assert property (s_jog_down |-> speed_cmd < 0)
    else $error("down key in jog did not give reverse speed");
  chk_cmd_off_zero: assert property ((!servo_enable && !jog_active)[*3] |-> speed_cmd == 0)
    else $error("speed command not zero with servo off");
  chk_apb_no_error: assert property (psel && penable |-> pready && !pslverr)
    else $error("apb access stalled or flagged an error");
  chk_freeze_hold: assert property (!clk_en |=> $stable(speed_cmd) && $stable(servo_enable))
    else $error("outputs moved while clock enable was low");
  chk_alarm_raise: assert property (alarm_event && clk_en |-> ##[1:3] alarm_active)
    else $error("alarm event did not raise the alarm");
endmodule : stsel_top_asserts

bind stsel_top stsel_top_asserts i_chk (.*);
`default_nettype wire

// ==== verification/stsel_host_model.sv ====
// host controller and keypad model: input pins and panel keys
// assumes callers enter its tasks just after a pclk edge
`timescale 1ns/1ps
`default_nettype none

module stsel_host_model (
  // clock
  input  wire logic       pclk,
  // digital input pins and panel keys
  output logic      [3:0] digital_in,
  output logic            key_set,
  output logic            key_mode,
  output logic            key_up,
  output logic            key_down,
  output logic            key_shift
);
  logic [4:0] keys = 5'h00;

  // ==========
  // key index: 0 set, 1 mode, 2 up, 3 down, 4 shift
  assign {key_shift, key_down, key_up, key_mode, key_set} = keys;
  initial digital_in = 4'h0;

  // host moves one input pin; servo-on and alarm reset are plain levels
  task automatic drive_di(input int i, input logic v);
    @(posedge pclk);
    digital_in[i] <= v;
  endtask : drive_di

  // operator holds or lets go of a key
  task automatic key(input int k, input logic v);
    @(posedge pclk);
    keys[k] <= v;
  endtask : key

  // full press: long enough for the synchroniser, then a gap so edges stay apart
  task automatic press(input int k);
    key(k, 1'b1);
    repeat (8) @(posedge pclk);
    key(k, 1'b0);
    repeat (4) @(posedge pclk);
  endtask : press
endmodule : stsel_host_model
`default_nettype wire

// ==== verification/stsel_top_tb.sv ====
// self-checking bench for stsel_top: apb master, host model, scenarios
// assumes stsel_pkg, the host model and the checker bind are compiled first
`timescale 1ns/1ps
`default_nettype none

module stsel_top_tb import stsel_pkg::*;;
  logic               pclk, presetn, clk_en, psel, penable, pwrite, alarm_event;
  logic        [7:0]  paddr;
  logic        [31:0] pwdata, prdata;
  logic               pready, pslverr, servo_enable, alarm_active, jog_active, trq_lim, irq;
  logic        [3:0]  digital_in;
  logic               key_set, key_mode, key_up, key_down, key_shift;
  logic signed [31:0] analog_speed, speed_cmd;
  int                 fails = 0, samples_checked = 0, cycles = 0;

  stsel_top i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .digital_in(digital_in), .key_set(key_set), .key_mode(key_mode), .key_up(key_up), .key_down(key_down),
    .key_shift(key_shift), .analog_speed(analog_speed), .alarm_event(alarm_event),
    .servo_enable(servo_enable), .alarm_active(alarm_active), .jog_active(jog_active),
    .torque_limit_active(trq_lim), .speed_cmd(speed_cmd), .irq(irq));
  stsel_host_model i_host (.pclk(pclk), .digital_in(digital_in), .key_set(key_set), .key_mode(key_mode),
    .key_up(key_up), .key_down(key_down), .key_shift(key_shift));

  // ==========
  // 100 MHz clock; cycle ceiling cuts a hang short
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wait_n(input int n);
    repeat (n) @(posedge pclk);
  endtask : wait_n

  // one apb transfer: setup, access held until pready, then release
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(nm, q, exp);
  endtask : rd_chk

  // reset values, preset limits just inside and outside, mode write
  task automatic t_regs();
    rd_chk("jog speed", ADDR_JOG_SPEED, 32'h0000_0014);
    wr(ADDR_PRESET1, 32'h0000_c350);
    wr(ADDR_PRESET1, 32'h0000_c351);
    rd_chk("preset max", ADDR_PRESET1, 32'h0000_c350);
    wr(ADDR_PRESET2, 32'hffff_3cb0);
    wr(ADDR_PRESET2, 32'hffff_3caf);
    rd_chk("preset min", ADDR_PRESET2, 32'hffff_3cb0);
    rd_chk("unmapped", 8'h3c, 32'h0);
    wr(ADDR_CTRL, 32'h0000_0020);
    rd_chk("mode pending", ADDR_CTRL, 32'h0000_0020);
    alarm_event <= 1'b1;
    wait_n(1);
    alarm_event <= 1'b0;
    wait_n(2);
    check("alarm before reset", alarm_active, 32'h1);
    presetn <= 1'b0;
    wait_n(3);
    presetn <= 1'b1;
    wait_n(1);
    check("alarm after reset", alarm_active, 32'h0);
    rd_chk("mode active", ADDR_CTRL, 32'h0000_0220);
    wr(ADDR_CTRL, 32'h0);
    rd_chk("mode kept", ADDR_CTRL, 32'h0000_0200);
    $display("test regs done");
  endtask : t_regs

  // software servo-on, all four select codes, then a frozen clock enable
  task automatic t_son();
    logic [31:0] e [4] = '{32'h0000_04d2, 32'h0000_7530, 32'h0000_03e8, 32'hffff_8ad0};
    analog_speed <= 32'sh0000_04d2;
    wr(ADDR_PRESET1, e[1]);
    wr(ADDR_PRESET2, e[2]);
    wr(ADDR_PRESET3, e[3]);
    wr(ADDR_CTRL, 32'h0000_0001);
    wait_n(3);
    check("servo sw", servo_enable, 32'h1);
    for (int s = 0; s < 4; s++) begin
      i_host.drive_di(2, s[0]);
      i_host.drive_di(3, s[1]);
      wait_n(6);
      check("speed cmd", speed_cmd, e[s]);
    end
    clk_en <= 1'b0;
    i_host.drive_di(2, 1'b0);
    wait_n(6);
    check("frozen cmd", speed_cmd, e[3]);
    clk_en <= 1'b1;
    wr(ADDR_CTRL, 32'h0);
    i_host.drive_di(3, 1'b0);
    wait_n(6);
    check("cmd off", speed_cmd, 32'h0);
    $display("test servo on done");
  endtask : t_son

  // servo-on pin followed, then ignored once its function code is zero
  task automatic t_di();
    i_host.drive_di(0, 1'b1);
    wait_n(5);
    check("servo pin on", servo_enable, 32'h1);
    i_host.drive_di(0, 1'b0);
    wait_n(5);
    check("servo pin off", servo_enable, 32'h0);
    i_host.drive_di(1, 1'b1);
    wait_n(5);
    check("torque limit", trq_lim, 32'h1);
    i_host.drive_di(1, 1'b0);
    wr(ADDR_DI_FUNC, 32'h1514_0900);
    i_host.drive_di(0, 1'b1);
    wait_n(6);
    check("disabled pin", servo_enable, 32'h0);
    i_host.drive_di(0, 1'b0);
    $display("test inputs done");
  endtask : t_di

  // alarm raised, cleared by the reset input; interrupt masked, raised, cleared
  task automatic t_alarm();
    wr(ADDR_STATUS, 32'h0000_000f);
    wr(ADDR_DI_FUNC, 32'h1514_0201);
    alarm_event <= 1'b1;
    wait_n(1);
    alarm_event <= 1'b0;
    wait_n(3);
    check("alarm set", alarm_active, 32'h1);
    i_host.drive_di(1, 1'b1);
    wait_n(5);
    check("alarm clear", alarm_active, 32'h0);
    check("irq masked", irq, 32'h0);
    rd_chk("status", ADDR_STATUS, 32'h1);
    wr(ADDR_MASK, 32'h1);
    check("irq raised", irq, 32'h1);
    wr(ADDR_STATUS, 32'h1);
    check("irq cleared", irq, 32'h0);
    i_host.drive_di(1, 1'b0);
    $display("test alarm done");
  endtask : t_alarm

  // digit edit 20 to 31, enter jog, run both ways, leave with mode
  task automatic t_jog();
    i_host.press(0);
    i_host.press(2);
    i_host.press(4);
    i_host.press(2);
    i_host.press(0);
    check("jog on", jog_active, 32'h1);
    rd_chk("jog edit", ADDR_JOG_SPEED, 32'h0000_001f);
    i_host.key(2, 1'b1);
    wait_n(8);
    check("jog fwd", speed_cmd, 32'h0000_0136);
    i_host.key(2, 1'b0);
    i_host.key(3, 1'b1);
    wait_n(8);
    check("jog rev", speed_cmd, 32'hffff_feca);
    i_host.key(3, 1'b0);
    i_host.press(1);
    check("jog off", jog_active, 32'h0);
    $display("test jog done");
  endtask : t_jog

  // reset for five cycles, then the scenarios in turn
  initial begin
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    analog_speed = 32'sh0;
    alarm_event = 1'b0;
    wait_n(5);
    presetn <= 1'b1;
    wait_n(1);
    t_regs();
    t_son();
    t_di();
    t_alarm();
    t_jog();
    give_verdict();
  end
endmodule : stsel_top_tb
`default_nettype wire
